// *** ccss_pkg.sv ***
// ccss_pkg: constants for the cpu clock source switch
// assumes a single 125 MHz clock and plain-port register access
package ccss_pkg;
   // oscillation mode register fields
   localparam int EXT_MAIN_BIT   = 7;
   localparam int MAIN_OSC_BIT   = 6;
   localparam int SUB_EXT_BIT    = 5;
   localparam int SUB_OSC_BIT    = 4;
   localparam int AMP_HIGH_BIT   = 0;
   // main oscillator control register
   localparam int MAIN_STOP_BIT  = 7;
   // main clock mode register
   localparam int MAIN_SYS_BIT   = 2;
   localparam int MAIN_ROUTE_BIT = 0;
   // processor clock control register
   localparam int SUB_FORCE_BIT  = 6;
   localparam int CPU_SUB_BIT    = 4;
   // ring oscillator mode register
   localparam int RING_STAT_BIT  = 7;
   localparam int RING_STOP_BIT  = 0;
   // reset values
   localparam logic [7:0] OSC_MODE_RST  = 8'h00;
   localparam logic [7:0] MAIN_CTL_RST  = 8'h80;
   localparam logic [7:0] MAIN_MODE_RST = 8'h00;
   localparam logic [7:0] PROC_CTL_RST  = 8'h00;
   localparam logic [7:0] RING_MODE_RST = 8'h00;
   // clock withheld after amplitude raise
   localparam int CLK_PERIOD_PS  = 8000;
   localparam int AMP_HOLD_NS    = 5000;
   localparam int AMP_HOLD_CYC   = (AMP_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [9:0] AMP_HOLD_CNT = 10'(AMP_HOLD_CYC);
   // clock sources and power states
   typedef enum logic [1:0] {SRC_RING, SRC_MAIN, SRC_SUB} ccss_src_t;
   typedef enum logic [2:0] {
      ST_RUN_RING, ST_RUN_MAIN, ST_RUN_SUB,
      ST_HALT_RING, ST_HALT_MAIN, ST_HALT_SUB,
      ST_STOP_RING, ST_STOP_MAIN
   } ccss_pwr_t;
endpackage : ccss_pkg

// *** ccss_glitchfree_mux.sv ***
// ccss_glitchfree_mux: one-hot gate select over three source enables
// assumes source enables are sampled in the MCLK domain
`timescale 1ns/10ps
`default_nettype none
module ccss_glitchfree_mux
(
   // clock and reset
   input  wire  logic        clk,
   input  wire  logic        rst,
   // selection
   input  wire  logic [1:0]  sel,
   input  wire  logic        hold,
   // gated one-hot grant
   output logic       [2:0]  grant_q
);
   logic [2:0] want;
   logic       idle_q;

   always_comb
   begin
      want = 3'h0;
      want[sel] = 1'b1;
   end

   // break before make: drop the old grant, spend two idle cycles, then grant
   // the new one, so no source is ever gated mid-pulse
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         grant_q <= 3'h1;
         idle_q  <= 1'b0;
      end
      else if (hold)
         grant_q <= 3'h0;
      else if (grant_q != want && grant_q != 3'h0)
         grant_q <= 3'h0;
      else if (grant_q == 3'h0)
      begin
         idle_q  <= ~idle_q;
         if (idle_q)
            grant_q <= want;
      end
      else
         idle_q <= 1'b0;
   end

   no_double_a : assert property (@(posedge clk) disable iff (rst)
      $onehot0(grant_q)) else $error("two clock grants at once");
endmodule : ccss_glitchfree_mux
`default_nettype wire

// *** ccss_clock_switch.sv ***
// ccss_clock_switch: cpu clock source selection, halt and stop states
// assumes register writes arrive as per-register strobes with 8-bit data
// Behaviour
// - after reset cpu runs from ring oscillator
// - amplitude and main select change once only
// - halt instruction enters halt state per source
// - stop from ring or main operation
// - oscillation mode bits seven to four, zero
// - main stop bit seven stops main oscillator
// - main select bit two, route bit zero
// - sub force bit six, cpu select four
// - ring status bit seven, stop bit zero
// - cpu select one feeds subsystem clock
// - amplitude raise withholds cpu clock 5 us
`timescale 1ns/10ps
`default_nettype none
module ccss_clock_switch
(
   // clock and reset
   input  wire  logic        MCLK,
   input  wire  logic        SRST,
   // register writes
   input  wire  logic [7:0]  WDATA,
   input  wire  logic        OSC_MODE_WR,
   input  wire  logic        MAIN_CTL_WR,
   input  wire  logic        MAIN_MODE_WR,
   input  wire  logic        PROC_CTL_WR,
   input  wire  logic        RING_MODE_WR,
   // register read-back
   output logic       [7:0]  OSC_MODE_RD,
   output logic       [7:0]  MAIN_CTL_RD,
   output logic       [7:0]  MAIN_MODE_RD,
   output logic       [7:0]  PROC_CTL_RD,
   output logic       [7:0]  RING_MODE_RD,
   // cpu instructions and wakeup
   input  wire  logic        HALT_EXEC,
   input  wire  logic        STOP_EXEC,
   input  wire  logic        WAKEUP,
   // oscillator controls and clock routing
   output logic              MAIN_OSC_EN,
   output logic              MAIN_EXT_EN,
   output logic              SUB_OSC_EN,
   output logic              SUB_EXT_EN,
   output logic              RING_OSC_EN,
   output logic              AMP_HIGH,
   output logic       [2:0]  CPU_CLK_GRANT,
   output logic              CPU_CLK_HOLD,
   output logic       [2:0]  PWR_STATE
);
   logic [7:0]            osc_mode_q;
   logic [7:0]            main_ctl_q;
   logic [7:0]            main_mode_q;
   logic [7:0]            proc_ctl_q;
   logic                  ring_stop_q;
   logic                  amp_done_q;
   logic                  sel_done_q;
   logic [9:0]            amp_cnt_q;
   ccss_pkg::ccss_src_t   src;
   ccss_pkg::ccss_pwr_t   pwr_q;
   logic                  gate_off;
   logic                  amp_rise;

   assign amp_rise = OSC_MODE_WR && !amp_done_q
                     && WDATA[ccss_pkg::AMP_HIGH_BIT] && !osc_mode_q[ccss_pkg::AMP_HIGH_BIT];

   // oscillation mode: amplitude bit is writable once after reset
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         osc_mode_q <= ccss_pkg::OSC_MODE_RST;
         amp_done_q <= 1'b0;
      end
      else if (OSC_MODE_WR)
      begin
         osc_mode_q[7:4] <= WDATA[7:4];
         if (!amp_done_q && WDATA[ccss_pkg::AMP_HIGH_BIT] != osc_mode_q[ccss_pkg::AMP_HIGH_BIT])
         begin
            osc_mode_q[ccss_pkg::AMP_HIGH_BIT] <= WDATA[ccss_pkg::AMP_HIGH_BIT];
            amp_done_q <= 1'b1;
         end
      end
   end

   // main oscillator control; stopped after reset
   always_ff @(posedge MCLK)
   begin
      if (SRST)
         main_ctl_q <= ccss_pkg::MAIN_CTL_RST;
      else if (MAIN_CTL_WR)
         main_ctl_q <= {WDATA[ccss_pkg::MAIN_STOP_BIT], 7'h00};
   end

   // main clock mode: select bit is writable once after reset
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         main_mode_q <= ccss_pkg::MAIN_MODE_RST;
         sel_done_q  <= 1'b0;
      end
      else if (MAIN_MODE_WR)
      begin
         main_mode_q[ccss_pkg::MAIN_ROUTE_BIT] <= WDATA[ccss_pkg::MAIN_ROUTE_BIT];
         if (!sel_done_q && WDATA[ccss_pkg::MAIN_SYS_BIT] != main_mode_q[ccss_pkg::MAIN_SYS_BIT])
         begin
            main_mode_q[ccss_pkg::MAIN_SYS_BIT] <= WDATA[ccss_pkg::MAIN_SYS_BIT];
            sel_done_q <= 1'b1;
         end
      end
   end

   // processor clock control
   always_ff @(posedge MCLK)
   begin
      if (SRST)
         proc_ctl_q <= ccss_pkg::PROC_CTL_RST;
      else if (PROC_CTL_WR)
         proc_ctl_q <= WDATA & 8'h50;
   end

   // ring oscillator mode
   always_ff @(posedge MCLK)
   begin
      if (SRST)
         ring_stop_q <= ccss_pkg::RING_MODE_RST[ccss_pkg::RING_STOP_BIT];
      else if (RING_MODE_WR)
         ring_stop_q <= WDATA[ccss_pkg::RING_STOP_BIT];
   end

   // amplitude raise withholds the cpu clock while the oscillator settles
   always_ff @(posedge MCLK)
   begin
      if (SRST)
         amp_cnt_q <= 10'h000;
      else if (amp_rise)
         amp_cnt_q <= ccss_pkg::AMP_HOLD_CNT;
      else if (amp_cnt_q != 10'h000)
         amp_cnt_q <= amp_cnt_q - 10'h001;
   end

   // source choice; ring oscillator unless software routes elsewhere
   always_comb
   begin
      if (proc_ctl_q[ccss_pkg::CPU_SUB_BIT])
         src = ccss_pkg::SRC_SUB;
      else if (main_mode_q[ccss_pkg::MAIN_SYS_BIT] && main_mode_q[ccss_pkg::MAIN_ROUTE_BIT])
         src = ccss_pkg::SRC_MAIN;
      else
         src = ccss_pkg::SRC_RING;
   end

   // power state: halt per source, stop only from ring or main
   always_ff @(posedge MCLK)
   begin
      if (SRST)
         pwr_q <= ccss_pkg::ST_RUN_RING;
      else
         unique case (pwr_q)
            ccss_pkg::ST_RUN_RING, ccss_pkg::ST_RUN_MAIN, ccss_pkg::ST_RUN_SUB:
            begin
               if (STOP_EXEC && src != ccss_pkg::SRC_SUB)
                  pwr_q <= (src == ccss_pkg::SRC_MAIN) ? ccss_pkg::ST_STOP_MAIN
                                                       : ccss_pkg::ST_STOP_RING;
               else if (HALT_EXEC)
                  pwr_q <= (src == ccss_pkg::SRC_MAIN) ? ccss_pkg::ST_HALT_MAIN :
                           (src == ccss_pkg::SRC_SUB)  ? ccss_pkg::ST_HALT_SUB
                                                       : ccss_pkg::ST_HALT_RING;
               else
                  pwr_q <= (src == ccss_pkg::SRC_MAIN) ? ccss_pkg::ST_RUN_MAIN :
                           (src == ccss_pkg::SRC_SUB)  ? ccss_pkg::ST_RUN_SUB
                                                       : ccss_pkg::ST_RUN_RING;
            end
            ccss_pkg::ST_HALT_RING, ccss_pkg::ST_HALT_MAIN, ccss_pkg::ST_HALT_SUB,
            ccss_pkg::ST_STOP_RING, ccss_pkg::ST_STOP_MAIN:
            begin
               if (WAKEUP)
                  pwr_q <= ccss_pkg::ST_RUN_RING;
            end
         endcase
   end

   // cpu clock gated off while held by the amplitude timer or sleeping
   assign gate_off = (amp_cnt_q != 10'h000) || amp_rise
                     || (pwr_q != ccss_pkg::ST_RUN_RING && pwr_q != ccss_pkg::ST_RUN_MAIN
                         && pwr_q != ccss_pkg::ST_RUN_SUB);

   ccss_glitchfree_mux u_mux
   (
      .clk     (MCLK),
      .rst     (SRST),
      .sel     (src),
      .hold    (gate_off),
      .grant_q (CPU_CLK_GRANT)
   );

   // both stop states halt the ring oscillator, only ST_STOP_MAIN halts main; the subsystem keeps running
   assign MAIN_OSC_EN   = osc_mode_q[ccss_pkg::MAIN_OSC_BIT] && !osc_mode_q[ccss_pkg::EXT_MAIN_BIT]
                          && !main_ctl_q[ccss_pkg::MAIN_STOP_BIT]
                          && pwr_q != ccss_pkg::ST_STOP_MAIN;
   assign MAIN_EXT_EN   = osc_mode_q[ccss_pkg::MAIN_OSC_BIT] && osc_mode_q[ccss_pkg::EXT_MAIN_BIT]
                          && !main_ctl_q[ccss_pkg::MAIN_STOP_BIT]
                          && pwr_q != ccss_pkg::ST_STOP_MAIN;
   assign SUB_OSC_EN    = proc_ctl_q[ccss_pkg::SUB_FORCE_BIT]
                          || (osc_mode_q[ccss_pkg::SUB_OSC_BIT] && !osc_mode_q[ccss_pkg::SUB_EXT_BIT]);
   assign SUB_EXT_EN    = !proc_ctl_q[ccss_pkg::SUB_FORCE_BIT]
                          && osc_mode_q[ccss_pkg::SUB_OSC_BIT] && osc_mode_q[ccss_pkg::SUB_EXT_BIT];
   assign RING_OSC_EN   = !ring_stop_q && pwr_q != ccss_pkg::ST_STOP_RING
                          && pwr_q != ccss_pkg::ST_STOP_MAIN;
   assign AMP_HIGH      = osc_mode_q[ccss_pkg::AMP_HIGH_BIT];
   assign CPU_CLK_HOLD  = gate_off;
   assign PWR_STATE     = pwr_q;
   assign OSC_MODE_RD   = osc_mode_q;
   assign MAIN_CTL_RD   = main_ctl_q;
   assign MAIN_MODE_RD  = main_mode_q;
   assign PROC_CTL_RD   = proc_ctl_q;
   assign RING_MODE_RD  = {RING_OSC_EN ? 1'b0 : 1'b1, 6'h00, ring_stop_q};

   amp_hold_a : assert property (@(posedge MCLK) disable iff (SRST)
      amp_rise |=> (CPU_CLK_GRANT == 3'h0) [*8]) else $error("clock not withheld");
   amp_once_a : assert property (@(posedge MCLK) disable iff (SRST)
      amp_done_q |=> $stable(osc_mode_q[ccss_pkg::AMP_HIGH_BIT]))
      else $error("amplitude changed twice");
   sel_once_a : assert property (@(posedge MCLK) disable iff (SRST)
      sel_done_q |=> $stable(main_mode_q[ccss_pkg::MAIN_SYS_BIT]))
      else $error("main select changed twice");
   reset_ring_a : assert property (@(posedge MCLK)
      SRST |=> pwr_q == ccss_pkg::ST_RUN_RING && CPU_CLK_GRANT == 3'h1)
      else $error("reset not on ring oscillator");

   // subsystem selected and clock not withheld for the whole handover span
   sequence sub_steady_s;
      (proc_ctl_q[ccss_pkg::CPU_SUB_BIT] && !gate_off) [*4];
   endsequence

   sub_route_a : assert property (@(posedge MCLK) disable iff (SRST)
      sub_steady_s |-> CPU_CLK_GRANT == 3'h4)
      else $error("subsystem not routed");
   halt_src_a : assert property (@(posedge MCLK) disable iff (SRST)
      HALT_EXEC && !STOP_EXEC && pwr_q == ccss_pkg::ST_RUN_SUB && src == ccss_pkg::SRC_SUB
      |=> pwr_q == ccss_pkg::ST_HALT_SUB) else $error("wrong halt state");
   no_sub_stop_a : assert property (@(posedge MCLK) disable iff (SRST)
      STOP_EXEC && src == ccss_pkg::SRC_SUB && pwr_q == ccss_pkg::ST_RUN_SUB
      |=> pwr_q != ccss_pkg::ST_STOP_RING && pwr_q != ccss_pkg::ST_STOP_MAIN)
      else $error("stop entered from subsystem");
   main_stop_a : assert property (@(posedge MCLK) disable iff (SRST)
      main_ctl_q[ccss_pkg::MAIN_STOP_BIT] |-> !MAIN_OSC_EN && !MAIN_EXT_EN)
      else $error("main not stopped");
endmodule : ccss_clock_switch
`default_nettype wire

// *** tb_top.sv ***
// tb_top: self-checking bench for the cpu clock source switch
// assumes register read-back and state show one cycle after the strobe edge
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int HOLD_MIN = 5000 / 8;
   logic       mclk;
   logic       srst;
   logic [7:0] wdata;
   logic [4:0] wr_sel;
   logic [2:0] cpu_q;
   logic [7:0] osc_rd, mctl_rd, mmode_rd, proc_rd, ring_rd;
   logic       main_osc_en, main_ext_en, sub_osc_en, sub_ext_en, ring_osc_en;
   logic       amp_high, hold;
   logic [2:0] grant, pwr;
   int         n_fail;
   int         samples_checked;
   int         n;

   ccss_clock_switch i_ccss_clock_switch
   (
      .MCLK(mclk), .SRST(srst), .WDATA(wdata),
      .OSC_MODE_WR(wr_sel[0]), .MAIN_CTL_WR(wr_sel[1]), .MAIN_MODE_WR(wr_sel[2]),
      .PROC_CTL_WR(wr_sel[3]), .RING_MODE_WR(wr_sel[4]),
      .OSC_MODE_RD(osc_rd), .MAIN_CTL_RD(mctl_rd), .MAIN_MODE_RD(mmode_rd),
      .PROC_CTL_RD(proc_rd), .RING_MODE_RD(ring_rd),
      .HALT_EXEC(cpu_q[0]), .STOP_EXEC(cpu_q[1]), .WAKEUP(cpu_q[2]),
      .MAIN_OSC_EN(main_osc_en), .MAIN_EXT_EN(main_ext_en), .SUB_OSC_EN(sub_osc_en),
      .SUB_EXT_EN(sub_ext_en), .RING_OSC_EN(ring_osc_en), .AMP_HIGH(amp_high),
      .CPU_CLK_GRANT(grant), .CPU_CLK_HOLD(hold), .PWR_STATE(pwr)
   );

   task automatic results();
      if (n_fail == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask : chk

   // strobe lasts exactly one cycle; result is sampled mid-cycle after it
   task automatic wr(input int r, input logic [7:0] d);
      @(posedge mclk);
      wdata  <= d;
      wr_sel <= 5'h01 << r;
      @(posedge mclk);
      wr_sel <= 5'h00;
      @(negedge mclk);
   endtask : wr

   task automatic cpu(input logic [2:0] v);
      @(posedge mclk);
      cpu_q <= v;
      @(posedge mclk);
      cpu_q <= 3'h0;
      @(negedge mclk);
   endtask : cpu

   // grant handover idles a few cycles, so poll with a bound
   task automatic wait_grant(input logic [2:0] exp);
      int i;
      i = 0;
      while (grant !== exp && i < 20)
      begin
         @(negedge mclk);
         i++;
      end
      chk(8'(grant), 8'(exp), "grant");
   endtask : wait_grant

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // a one-hot grant must never show two sources at once
   always @(negedge mclk)
      if (!srst && !$onehot0(grant))
         chk(8'(grant), 8'h00, "overlapping grant");

   initial
   begin
      #(8 * 5000);
      n_fail++;
      results();
   end

   initial
   begin
      srst    = 1'b1;
      wdata   = 8'h00;
      wr_sel  = 5'h00;
      cpu_q   = 3'h0;
      n_fail  = 0;
      samples_checked = 0;
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      chk(8'(grant), 8'h01, "reset grant");
      chk(8'(pwr), 8'(ccss_pkg::ST_RUN_RING), "reset state");
      chk(osc_rd, 8'h00, "osc mode reset");
      chk(mctl_rd, 8'h80, "main ctl reset");
      chk(mmode_rd, 8'h00, "main mode reset");
      chk(proc_rd, 8'h00, "proc ctl reset");
      chk(ring_rd, 8'h00, "ring mode reset");
      chk(8'(main_osc_en), 8'h00, "main osc off");
      chk(8'(ring_osc_en), 8'h01, "ring on");
      // external main clock at high frequency: no stabilization poll
      wr(0, 8'hc1);
      chk(osc_rd, 8'hc1, "osc mode");
      chk(8'(amp_high), 8'h01, "amplitude");
      chk(8'(grant), 8'h00, "grant withheld");
      n = 1;
      while (hold === 1'b1 && n < 1000)
      begin
         @(negedge mclk);
         n++;
      end
      chk(8'(n >= HOLD_MIN && n <= HOLD_MIN + 8), 8'h01, "hold length");
      wr(1, 8'h00);
      chk(mctl_rd, 8'h00, "main stop cleared");
      chk(8'(main_ext_en), 8'h01, "ext main input");
      wr(2, 8'h05);
      chk(mmode_rd, 8'h05, "main mode");
      wait_grant(3'h2);
      // once-only fields keep their first value
      wr(0, 8'h40);
      chk(osc_rd, 8'h41, "amplitude locked");
      chk(8'(hold), 8'h00, "no new hold");
      chk(8'(main_osc_en), 8'h01, "main crystal on");
      chk(8'(main_ext_en), 8'h00, "ext main off");
      wr(0, 8'hc1);
      wr(2, 8'h01);
      chk(mmode_rd, 8'h05, "main select locked");
      wr(2, 8'h04);
      wait_grant(3'h1);
      wr(2, 8'h05);
      wait_grant(3'h2);
      // subsystem: forced crystal, then external input
      wr(3, 8'h40);
      chk(proc_rd, 8'h40, "sub force");
      chk(8'(sub_osc_en), 8'h01, "sub crystal");
      wr(3, 8'h00);
      wr(0, 8'hf1);
      chk(8'(sub_ext_en), 8'h01, "sub ext input");
      wr(3, 8'h10);
      wait_grant(3'h4);
      cpu(3'h1);
      chk(8'(pwr), 8'(ccss_pkg::ST_HALT_SUB), "halt sub");
      cpu(3'h4);
      wait_grant(3'h4);
      cpu(3'h2);
      chk(8'(pwr), 8'(ccss_pkg::ST_RUN_SUB), "stop refused on sub");
      // back to the main clock, then halt and stop there
      wr(3, 8'h00);
      wait_grant(3'h2);
      cpu(3'h1);
      chk(8'(pwr), 8'(ccss_pkg::ST_HALT_MAIN), "halt main");
      cpu(3'h4);
      wait_grant(3'h2);
      cpu(3'h2);
      chk(8'(pwr), 8'(ccss_pkg::ST_STOP_MAIN), "stop main");
      chk(8'(main_ext_en), 8'h00, "main input off in stop");
      chk(8'(ring_osc_en), 8'h00, "ring off in stop");
      cpu(3'h4);
      wait_grant(3'h2);
      // ring oscillator as cpu clock with main kept for peripherals
      wr(2, 8'h04);
      wait_grant(3'h1);
      cpu(3'h1);
      chk(8'(pwr), 8'(ccss_pkg::ST_HALT_RING), "halt ring");
      cpu(3'h4);
      wait_grant(3'h1);
      cpu(3'h2);
      chk(8'(pwr), 8'(ccss_pkg::ST_STOP_RING), "stop ring");
      cpu(3'h4);
      wait_grant(3'h1);
      // ring may stop only once the cpu runs from main
      wr(2, 8'h05);
      wait_grant(3'h2);
      wr(4, 8'h01);
      chk(ring_rd, 8'h81, "ring stopped status");
      chk(8'(ring_osc_en), 8'h00, "ring off");
      // a second reset in mid-run re-arms the once-only amplitude field
      @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      chk(8'(grant), 8'h01, "second reset grant");
      chk(8'(pwr), 8'(ccss_pkg::ST_RUN_RING), "second reset state");
      chk(osc_rd, 8'h00, "second reset osc mode");
      wr(0, 8'h11);
      chk(osc_rd, 8'h11, "amplitude re-armed");
      chk(8'(hold), 8'h01, "hold after re-arm");
      chk(8'(sub_osc_en), 8'h01, "sub crystal by select");
      chk(8'(sub_ext_en), 8'h00, "sub ext off");
      results();
   end
endmodule : tb_top
`default_nettype wire
